// >>> ccf_pkg.sv
// Package for the condition flag register block
package ccf_pkg;
    localparam int CCF_W = 8;
    localparam int BIT_IMASK = 7;
    localparam int BIT_UI = 6;
    localparam int BIT_H = 5;
    localparam int BIT_U = 4;
    localparam int BIT_N = 3;
    localparam int BIT_Z = 2;
    localparam int BIT_V = 1;
    localparam int BIT_C = 0;
    localparam logic [7:0] USER_MASK = 8'h50;

    typedef enum logic [1:0] {SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2} ccf_size_t;

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ADD = 4'h1,
        OP_SUB = 4'h2,
        OP_LOGIC = 4'h3,
        OP_SHIFT = 4'h4,
        OP_BITLD = 4'h5,
        OP_BITAND = 4'h6,
        OP_BITOR = 4'h7,
        OP_BITXOR = 4'h8,
        OP_MOV = 4'h9
    } ccf_op_t;

    typedef enum logic [2:0] {
        CTL_NONE = 3'h0,
        CTL_LOAD = 3'h1,
        CTL_AND = 3'h2,
        CTL_OR = 3'h3,
        CTL_XOR = 3'h4
    } ccf_ctl_t;

    // Datapath result as seen by the flag logic
    typedef struct packed {
        ccf_op_t op;
        ccf_size_t size;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] res;
        logic shift_out;
        logic bit_in;
    } ccf_alu_t;

    typedef struct packed {
        logic h;
        logic n;
        logic z;
        logic v;
        logic c;
        logic upd_h;
        logic upd_nzv;
        logic upd_c;
    } ccf_flags_t;
endpackage

// >>> ccf_eval.sv
// Flag computation from a datapath result
`timescale 1ns/1ns
module ccf_eval
    import ccf_pkg::*;
(
    input wire ccf_alu_t i_alu,
    input wire logic i_c,
    output ccf_flags_t o_flags
);
    function automatic logic msb_of(input logic [31:0] d, input ccf_size_t s);
        case (s)
            SZ_B: msb_of = d[7];
            SZ_W: msb_of = d[15];
            default: msb_of = d[31];
        endcase
    endfunction

    function automatic logic is_zero(input logic [31:0] d, input ccf_size_t s);
        case (s)
            SZ_B: is_zero = (d[7:0] == 8'h00);
            SZ_W: is_zero = (d[15:0] == 16'h0000);
            default: is_zero = (d == 32'h0000_0000);
        endcase
    endfunction

    function automatic logic half_of(input logic [31:0] d, input ccf_size_t s);
        case (s)
            SZ_B: half_of = d[4];
            SZ_W: half_of = d[12];
            default: half_of = d[28];
        endcase
    endfunction

    logic sa, sb, sr, carry, half;

    always_comb begin
        sa = msb_of(i_alu.a, i_alu.size);
        sb = msb_of(i_alu.b, i_alu.size);
        sr = msb_of(i_alu.res, i_alu.size);
        // Carry out of the msb from the sign bits of a, b, res; half carry from a^b^res above the half digit
        half = half_of(i_alu.a ^ i_alu.b ^ i_alu.res, i_alu.size);
        if (i_alu.op == OP_ADD) begin
            carry = (sa & sb) | ((sa | sb) & ~sr);
        end else begin
            carry = (~sa & sb) | ((~sa | sb) & sr);
        end
        o_flags = '0;
        o_flags.n = sr;
        o_flags.z = is_zero(i_alu.res, i_alu.size);
        case (i_alu.op)
            OP_ADD: begin
                o_flags.h = half;
                o_flags.v = (sa == sb) && (sr != sa);
                o_flags.c = carry;
                o_flags.upd_h = 1'b1;
                o_flags.upd_nzv = 1'b1;
                o_flags.upd_c = 1'b1;
            end
            OP_SUB: begin
                o_flags.h = half;
                o_flags.v = (sa != sb) && (sr != sa);
                o_flags.c = carry;
                o_flags.upd_h = 1'b1;
                o_flags.upd_nzv = 1'b1;
                o_flags.upd_c = 1'b1;
            end
            OP_LOGIC, OP_MOV: begin
                o_flags.upd_nzv = 1'b1;
            end
            OP_SHIFT: begin
                o_flags.c = i_alu.shift_out;
                o_flags.upd_nzv = 1'b1;
                o_flags.upd_c = 1'b1;
            end
            OP_BITLD: begin
                o_flags.c = i_alu.bit_in;
                o_flags.upd_c = 1'b1;
            end
            OP_BITAND: begin
                o_flags.c = i_c & i_alu.bit_in;
                o_flags.upd_c = 1'b1;
            end
            OP_BITOR: begin
                o_flags.c = i_c | i_alu.bit_in;
                o_flags.upd_c = 1'b1;
            end
            OP_BITXOR: begin
                o_flags.c = i_c ^ i_alu.bit_in;
                o_flags.upd_c = 1'b1;
            end
            default: begin
                o_flags.upd_h = 1'b0;
            end
        endcase
    end
endmodule

// >>> ccf_top.sv
// Condition flag register with branch condition evaluation
// Functional notes
// - Eight bits: I UI H U N Z V C
// - Mask bit set blocks maskable interrupts
// - Non-maskable interrupt always accepted
// - Exception entry sets the mask bit
// - Reset sets the mask bit
// - Reset leaves other bits untouched
// - Software reads, loads, ANDs, ORs, XORs register
// - User bits only store software values
// - Half-carry from bit 3, 11, 27
// - Negative takes result sign bit
// - Zero set when result is zero
// - Overflow set on arithmetic overflow only
// - Carry records carry, borrow, shifted-out bit
// - Bit instructions use carry as accumulator
// - Branches test N, Z, V, C
`timescale 1ns/1ns
module ccf_top
    import ccf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_alu_valid,
    input wire ccf_alu_t i_alu,
    input wire ccf_ctl_t i_ctl_op,
    input wire logic [7:0] i_ctl_data,
    input wire logic i_exc_entry,
    input wire logic i_irq_maskable,
    input wire logic i_irq_nmi,
    input wire logic [3:0] i_cond,
    output logic [7:0] o_condition_flags_register,
    output logic o_irq_accept,
    output logic o_nmi_accept,
    output logic o_branch_taken
);
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    ccf_flags_t upd;

    ccf_eval u_eval (
        .i_alu(i_alu),
        .i_c(flags_reg[BIT_C]),
        .o_flags(upd)
    );

    always_comb begin
        flags_next = flags_reg;
        if (i_ctl_op == CTL_LOAD) begin
            flags_next = i_ctl_data;
        end else if (i_ctl_op == CTL_AND) begin
            flags_next = flags_reg & i_ctl_data;
        end else if (i_ctl_op == CTL_OR) begin
            flags_next = flags_reg | i_ctl_data;
        end else if (i_ctl_op == CTL_XOR) begin
            flags_next = flags_reg ^ i_ctl_data;
        end else if (i_alu_valid) begin
            if (upd.upd_h) begin
                flags_next[BIT_H] = upd.h;
            end
            if (upd.upd_nzv) begin
                flags_next[BIT_N] = upd.n;
                flags_next[BIT_Z] = upd.z;
                flags_next[BIT_V] = upd.v;
            end
            if (upd.upd_c) begin
                flags_next[BIT_C] = upd.c;
            end
        end
        // Exception entry wins over any same-cycle instruction effect on the mask bit
        if (i_exc_entry) begin
            flags_next[BIT_IMASK] = 1'b1;
        end
    end

    // Only the mask bit is reset; the rest still take flags_next during reset
    always_ff @(posedge i_clk) begin
        flags_reg[BIT_IMASK - 1:0] <= flags_next[BIT_IMASK - 1:0];
        if (!i_nrst) begin
            flags_reg[BIT_IMASK] <= 1'b1;
        end else begin
            flags_reg[BIT_IMASK] <= flags_next[BIT_IMASK];
        end
    end

    function automatic logic cond_eval(input logic [3:0] cc, input logic [7:0] f);
        logic c, v, z, n;
        c = f[BIT_C];
        v = f[BIT_V];
        z = f[BIT_Z];
        n = f[BIT_N];
        case (cc)
            4'h0: cond_eval = 1'b1;
            4'h1: cond_eval = 1'b0;
            4'h2: cond_eval = ~(c | z);
            4'h3: cond_eval = c | z;
            4'h4: cond_eval = ~c;
            4'h5: cond_eval = c;
            4'h6: cond_eval = ~z;
            4'h7: cond_eval = z;
            4'h8: cond_eval = ~v;
            4'h9: cond_eval = v;
            4'ha: cond_eval = ~n;
            4'hb: cond_eval = n;
            4'hc: cond_eval = ~(n ^ v);
            4'hd: cond_eval = n ^ v;
            4'he: cond_eval = ~(z | (n ^ v));
            default: cond_eval = z | (n ^ v);
        endcase
    endfunction

    always_comb begin
        o_condition_flags_register = flags_reg;
        o_branch_taken = cond_eval(i_cond, flags_reg);
        o_irq_accept = i_irq_maskable & ~flags_reg[BIT_IMASK];
        o_nmi_accept = i_irq_nmi;
    end

    // Reference sum for the checks, kept apart from the flag logic it judges
    logic [8:0] ovf_sum;

    always_comb begin
        ovf_sum = {i_alu.a[7], i_alu.a[7:0]} + {i_alu.b[7], i_alu.b[7:0]};
    end

    // A datapath step counts only when no control write shares its cycle
    sequence s_idle_step;
        i_ctl_op == CTL_NONE && !i_alu_valid;
    endsequence

    sequence s_add_byte;
        i_ctl_op == CTL_NONE && i_alu_valid && i_alu.op == OP_ADD && i_alu.size == SZ_B;
    endsequence

    sequence s_sub_byte;
        i_ctl_op == CTL_NONE && i_alu_valid && i_alu.op == OP_SUB && i_alu.size == SZ_B;
    endsequence

    sequence s_logic_byte;
        i_ctl_op == CTL_NONE && i_alu_valid && i_alu.op == OP_LOGIC && i_alu.size == SZ_B;
    endsequence

    sequence s_logic_word;
        i_ctl_op == CTL_NONE && i_alu_valid && i_alu.op == OP_LOGIC && i_alu.size == SZ_W;
    endsequence

    sequence s_bit_and;
        i_ctl_op == CTL_NONE && i_alu_valid && i_alu.op == OP_BITAND;
    endsequence

    // Two steps: software opens the mask, then an exception starts
    sequence s_unmask_then_exc;
        (i_ctl_op == CTL_LOAD && !i_ctl_data[BIT_IMASK] && !i_exc_entry) ##1 i_exc_entry;
    endsequence

    chk_reset_mask: assert property (@(posedge i_clk)
        !i_nrst |=> flags_reg[BIT_IMASK])
        else $error("mask bit not set after reset");
    chk_reset_keep: assert property (@(posedge i_clk)
        (!i_nrst && i_ctl_op == CTL_NONE && !i_alu_valid)
        |=> flags_reg[BIT_IMASK - 1:0] == $past(flags_reg[BIT_IMASK - 1:0]))
        else $error("reset disturbed the unreset flag bits");
    chk_exc_mask: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_exc_entry |=> flags_reg[BIT_IMASK])
        else $error("mask bit not set on exception entry");
    chk_exc_order: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_unmask_then_exc |=> flags_reg[BIT_IMASK] && !o_irq_accept)
        else $error("exception after unmask left interrupts open");
    chk_irq_block: assert property (@(posedge i_clk) disable iff (!i_nrst)
        flags_reg[BIT_IMASK] |-> !o_irq_accept)
        else $error("maskable interrupt accepted while masked");
    chk_irq_open: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (!flags_reg[BIT_IMASK] && i_irq_maskable) |-> o_irq_accept)
        else $error("maskable interrupt refused while unmasked");
    chk_nmi_pass: assert property (@(posedge i_clk) disable iff (!i_nrst)
        i_irq_nmi |-> o_nmi_accept)
        else $error("nmi refused");

    chk_ctl_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ctl_op == CTL_LOAD && !i_exc_entry) |=> flags_reg == $past(i_ctl_data))
        else $error("load of flag register failed");
    chk_ctl_and: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ctl_op == CTL_AND && !i_exc_entry)
        |=> flags_reg == ($past(flags_reg) & $past(i_ctl_data)))
        else $error("and of flag register failed");
    chk_ctl_or: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ctl_op == CTL_OR && !i_exc_entry)
        |=> flags_reg == ($past(flags_reg) | $past(i_ctl_data)))
        else $error("or of flag register failed");
    chk_ctl_xor: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ctl_op == CTL_XOR && !i_exc_entry)
        |=> flags_reg == ($past(flags_reg) ^ $past(i_ctl_data)))
        else $error("xor of flag register failed");
    chk_user_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ctl_op == CTL_NONE)
        |=> ((flags_reg & USER_MASK) == ($past(flags_reg) & USER_MASK)))
        else $error("user bits changed by hardware");

    chk_half_add: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_add_byte
        |=> flags_reg[BIT_H] == $past(({1'b0, i_alu.a[3:0]} + {1'b0, i_alu.b[3:0]}) > 5'h0f))
        else $error("half carry wrong on add");
    chk_half_sub: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_sub_byte |=> flags_reg[BIT_H] == $past(i_alu.a[3:0] < i_alu.b[3:0]))
        else $error("half borrow wrong on subtract");
    chk_neg_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_logic_word |=> flags_reg[BIT_N] == $past(i_alu.res[15]))
        else $error("negative flag wrong");
    chk_zero_flag: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_logic_byte |=> flags_reg[BIT_Z] == $past(i_alu.res[7:0] == 8'h00))
        else $error("zero flag wrong");
    chk_logic_ovf: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_logic_byte |=> !flags_reg[BIT_V])
        else $error("overflow left set by logic result");
    chk_add_ovf: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_add_byte |=> flags_reg[BIT_V] == $past(ovf_sum[8] ^ ovf_sum[7]))
        else $error("overflow wrong on add");
    chk_add_carry: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_add_byte
        |=> flags_reg[BIT_C] == $past(({1'b0, i_alu.a[7:0]} + {1'b0, i_alu.b[7:0]}) > 9'h0ff))
        else $error("add carry wrong");
    chk_sub_borrow: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_sub_byte |=> flags_reg[BIT_C] == $past(i_alu.a[7:0] < i_alu.b[7:0]))
        else $error("subtract borrow wrong");
    chk_shift_carry: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_ctl_op == CTL_NONE && i_alu_valid && i_alu.op == OP_SHIFT)
        |=> flags_reg[BIT_C] == $past(i_alu.shift_out))
        else $error("shifted out bit not in carry");

    chk_bit_and: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_bit_and |=> flags_reg[BIT_C] == $past(flags_reg[BIT_C] & i_alu.bit_in))
        else $error("bit accumulate wrong");
    chk_bit_keep: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_bit_and |=> flags_reg[BIT_H:BIT_V] == $past(flags_reg[BIT_H:BIT_V]))
        else $error("bit operation touched other flags");
    chk_branch_eq: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_cond == 4'h7) |-> o_branch_taken == flags_reg[BIT_Z])
        else $error("equal branch decision wrong");
    chk_branch_lt: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (i_cond == 4'hd) |-> o_branch_taken == (flags_reg[BIT_N] ^ flags_reg[BIT_V]))
        else $error("less than branch decision wrong");
    chk_flags_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
        s_idle_step |=> flags_reg[BIT_H:0] == $past(flags_reg[BIT_H:0]))
        else $error("flags changed without cause");
endmodule

// >>> ccf_top_bench.sv
// Self-checking bench for the condition flag register
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ccf_top_bench
    import ccf_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_alu_valid = 1'b0;
    ccf_alu_t i_alu = '0;
    // A load runs through reset so the bits reset leaves alone are known at release
    ccf_ctl_t i_ctl_op = CTL_LOAD;
    logic [7:0] i_ctl_data = 8'h3c;
    logic i_exc_entry = 1'b0;
    logic i_irq_maskable = 1'b0;
    logic i_irq_nmi = 1'b0;
    logic [3:0] i_cond = 4'h0;
    logic [7:0] o_flags;
    logic o_irq_accept;
    logic o_nmi_accept;
    logic o_branch_taken;
    int err_count = 0;
    int checks_done = 0;

    always #2 i_clk = ~i_clk;

    ccf_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_alu_valid(i_alu_valid), .i_alu(i_alu),
        .i_ctl_op(i_ctl_op), .i_ctl_data(i_ctl_data), .i_exc_entry(i_exc_entry),
        .i_irq_maskable(i_irq_maskable), .i_irq_nmi(i_irq_nmi), .i_cond(i_cond),
        .o_condition_flags_register(o_flags), .o_irq_accept(o_irq_accept),
        .o_nmi_accept(o_nmi_accept), .o_branch_taken(o_branch_taken));

    task automatic results();
        $display("Checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Control instruction for one cycle, then compare the register
    task automatic ctl(input ccf_ctl_t op, input logic [7:0] d, input logic [7:0] exp);
        @(negedge i_clk);
        i_ctl_op = op;
        i_ctl_data = d;
        @(negedge i_clk);
        i_ctl_op = CTL_NONE;
        `CHK(o_flags, exp)
    endtask

    // Preload, one datapath result, compare
    task automatic alu(input logic [7:0] pre, input ccf_op_t op, input ccf_size_t sz,
        input logic [31:0] a, input logic [31:0] b, input logic [31:0] r,
        input logic so, input logic bi, input logic [7:0] exp);
        ctl(CTL_LOAD, pre, pre);
        @(negedge i_clk);
        i_alu_valid = 1'b1;
        i_alu = '{op: op, size: sz, a: a, b: b, res: r, shift_out: so, bit_in: bi};
        @(negedge i_clk);
        i_alu_valid = 1'b0;
        `CHK(o_flags, exp)
    endtask

    // Reference branch decision from N Z V C
    function automatic logic br_exp(input logic [3:0] cd, input logic [3:0] f);
        case (cd)
            4'h0: br_exp = 1'b1;
            4'h1: br_exp = 1'b0;
            4'h2: br_exp = ~(f[0] | f[2]);
            4'h3: br_exp = f[0] | f[2];
            4'h4: br_exp = ~f[0];
            4'h5: br_exp = f[0];
            4'h6: br_exp = ~f[2];
            4'h7: br_exp = f[2];
            4'h8: br_exp = ~f[1];
            4'h9: br_exp = f[1];
            4'ha: br_exp = ~f[3];
            4'hb: br_exp = f[3];
            4'hc: br_exp = ~(f[3] ^ f[1]);
            4'hd: br_exp = f[3] ^ f[1];
            4'he: br_exp = ~(f[2] | (f[3] ^ f[1]));
            default: br_exp = f[2] | (f[3] ^ f[1]);
        endcase
    endfunction

    // Hang guard
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        results();
    end

    initial begin
        repeat (4) @(negedge i_clk);
        `CHK(o_flags, 8'hbc)
        i_nrst = 1'b1;
        i_ctl_op = CTL_NONE;
        ctl(CTL_LOAD, 8'h00, 8'h00);
        ctl(CTL_LOAD, 8'hff, 8'hff);
        ctl(CTL_AND, 8'h0f, 8'h0f);
        ctl(CTL_OR, 8'h50, 8'h5f);
        ctl(CTL_XOR, 8'h0f, 8'h50);
        // Reset mid-run only sets the mask bit
        ctl(CTL_LOAD, 8'h55, 8'h55);
        i_nrst = 1'b0;
        @(negedge i_clk);
        i_nrst = 1'b1;
        `CHK(o_flags, 8'hd5)
        // Interrupt gating by the mask bit
        ctl(CTL_LOAD, 8'h00, 8'h00);
        i_irq_maskable = 1'b1;
        i_irq_nmi = 1'b1;
        i_exc_entry = 1'b1;
        #1;
        `CHK(o_irq_accept, 1'b1)
        `CHK(o_nmi_accept, 1'b1)
        @(negedge i_clk);
        i_exc_entry = 1'b0;
        `CHK(o_flags, 8'h80)
        `CHK(o_irq_accept, 1'b0)
        `CHK(o_nmi_accept, 1'b1)
        i_irq_nmi = 1'b0;
        i_irq_maskable = 1'b0;
        #1;
        `CHK(o_nmi_accept, 1'b0)
        `CHK(o_irq_accept, 1'b0)
        // User bits ride through every datapath update
        alu(8'h50, OP_ADD, SZ_B, 32'h0f, 32'h01, 32'h10, 1'b0, 1'b0, 8'h70);
        alu(8'h50, OP_ADD, SZ_B, 32'h7f, 32'h01, 32'h80, 1'b0, 1'b0, 8'h7a);
        alu(8'h50, OP_ADD, SZ_B, 32'hff, 32'h01, 32'h00, 1'b0, 1'b0, 8'h75);
        alu(8'h50, OP_ADD, SZ_W, 32'hfff, 32'h1, 32'h1000, 1'b0, 1'b0, 8'h70);
        alu(8'h50, OP_ADD, SZ_W, 32'hff, 32'h1, 32'h100, 1'b0, 1'b0, 8'h50);
        alu(8'h50, OP_ADD, SZ_L, 32'hfffffff, 32'h1, 32'h10000000, 1'b0, 1'b0, 8'h70);
        alu(8'h50, OP_SUB, SZ_B, 32'h00, 32'h01, 32'hff, 1'b0, 1'b0, 8'h79);
        alu(8'h50, OP_SUB, SZ_B, 32'h80, 32'h01, 32'h7f, 1'b0, 1'b0, 8'h72);
        alu(8'h53, OP_LOGIC, SZ_B, 32'h0, 32'h0, 32'h00, 1'b0, 1'b0, 8'h55);
        alu(8'h70, OP_LOGIC, SZ_B, 32'h0, 32'h0, 32'h80, 1'b0, 1'b0, 8'h78);
        alu(8'h50, OP_LOGIC, SZ_W, 32'h0, 32'h0, 32'h8000, 1'b0, 1'b0, 8'h58);
        alu(8'h5f, OP_MOV, SZ_W, 32'h0, 32'h0, 32'h0, 1'b0, 1'b0, 8'h55);
        alu(8'h50, OP_SHIFT, SZ_B, 32'h0, 32'h0, 32'h40, 1'b1, 1'b0, 8'h51);
        alu(8'h50, OP_BITLD, SZ_B, 32'h0, 32'h0, 32'h0, 1'b0, 1'b1, 8'h51);
        alu(8'h51, OP_BITAND, SZ_B, 32'h0, 32'h0, 32'h0, 1'b0, 1'b0, 8'h50);
        alu(8'h50, OP_BITOR, SZ_B, 32'h0, 32'h0, 32'h0, 1'b0, 1'b1, 8'h51);
        alu(8'h51, OP_BITXOR, SZ_B, 32'h0, 32'h0, 32'h0, 1'b0, 1'b1, 8'h50);
        // Result left on the bus without valid must not update
        @(negedge i_clk);
        `CHK(o_flags, 8'h50)
        // Control write beats the datapath; exception entry beats both on the mask bit
        i_ctl_op = CTL_LOAD;
        i_ctl_data = 8'h42;
        i_alu_valid = 1'b1;
        i_exc_entry = 1'b1;
        @(negedge i_clk);
        i_ctl_op = CTL_NONE;
        i_alu_valid = 1'b0;
        i_exc_entry = 1'b0;
        `CHK(o_flags, 8'hc2)
        // Every branch condition against every N Z V C pattern
        for (int f = 0; f < 16; f++) begin
            ctl(CTL_LOAD, 8'(f), 8'(f));
            for (int cd = 0; cd < 16; cd++) begin
                @(negedge i_clk);
                i_cond = 4'(cd);
                #1;
                `CHK(o_branch_taken, br_exp(4'(cd), 4'(f)))
            end
        end
        results();
    end
endmodule
